// ===== hw/rail_supervision_and_soft_ramp.sv
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "rail_supervision_params.svh"

module rail_supervision_and_soft_ramp #(
  parameter int unsigned SAMPLE_CYC   = `AUX_SAMPLE_CYC,
  parameter int unsigned INTERVAL_SMP = `AUX_INTERVAL_SMP,
  parameter int unsigned RAMP_CYC     = `RAMP_TICK_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // power stage sense
  input  wire logic [11:0] input_voltage_sense_pin,
  input  wire logic [15:0] differential_feedback_pins,
  input  wire logic [15:0] output_current,
  input  wire logic        error_converter_sat_hi,
  input  wire logic        error_converter_sat_lo,
  input  wire logic [15:0] computed_duty,
  input  wire logic [47:0] aux_converter_in,
  // control outputs
  output logic             pulse_width_outputs_en,
  output logic      [15:0] vref_dac,
  output logic      [1:0]  gain_bank_sel,
  output logic      [31:0] gain_coeff,
  output logic             over_temp_sample,
  output logic      [15:0] temp_filtered
);

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [31:0] ctrl_q, vout_q, dly_q, rise_q, fall_q, mind_q;
  logic [31:0] ocl_q, fold_q, vsc_q, vov_q, vuv_q, von_q, voff_q;
  logic [31:0] gb0_q, gb1_q, gb2_q, eccw_q;
  logic [37:0] ecc_word_q;
  logic [5:0]  ecc_gen;

  // write decode and storage
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= 32'h0; vout_q <= 32'h0; dly_q <= 32'h0;
      rise_q <= 32'h1; fall_q <= 32'h1; mind_q <= 32'h0;
      ocl_q <= 32'hffff; fold_q <= 32'h0; vsc_q <= 32'h1;
      vov_q <= 32'hffff; vuv_q <= 32'h0; von_q <= 32'h0;
      voff_q <= 32'h0; gb0_q <= 32'h0; gb1_q <= 32'h0;
      gb2_q <= 32'h0; eccw_q <= 32'h0; ecc_word_q <= 38'h0;
    end else if (wr) begin
      case (addr)
        `REG_CTRL:        ctrl_q <= wdata;
        `REG_VOUT_CMD:    vout_q <= wdata;
        `REG_START_DELAY: dly_q  <= wdata;
        `REG_RISE_STEP:   rise_q <= wdata;
        `REG_FALL_STEP:   fall_q <= wdata;
        `REG_MIN_DUTY:    mind_q <= wdata;
        `REG_OC_LIMIT:    ocl_q  <= wdata;
        `REG_FOLD_MIN:    fold_q <= wdata;
        `REG_VIN_SCALE:   vsc_q  <= wdata;
        `REG_VIN_OV:      vov_q  <= wdata;
        `REG_VIN_UV:      vuv_q  <= wdata;
        `REG_VIN_ON:      von_q  <= wdata;
        `REG_VIN_OFF:     voff_q <= wdata;
        `REG_GAIN_BANK0:  gb0_q  <= wdata;
        `REG_GAIN_BANK1:  gb1_q  <= wdata;
        `REG_GAIN_BANK2:  gb2_q  <= wdata;
        `REG_ECC_WDATA: begin
          eccw_q     <= wdata;
          ecc_word_q <= {ecc_gen, wdata};
        end
        `REG_ECC_CHECK:   ecc_word_q <= {wdata[5:0], eccw_q};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ecc: hamming over 32 data bits, six check bits
  logic [5:0]  ecc_syn;
  logic [31:0] ecc_fixed;
  logic        ecc_err;

  // check bits of the word on the write bus

  function automatic logic [5:0] ecc_code(input logic [31:0] d);
    logic [5:0] c;
    c = 6'h0;
    for (int i = 0; i < 32; i++) begin
      c = c ^ (6'(i + 1) | 6'h20) ^ 6'h20 ^ (d[i] ? 6'(i + 1) : 6'h0)
          ^ (6'(i + 1) | 6'h20) ^ 6'h20;
    end
    return c;
  endfunction : ecc_code

  // generator and syndrome; a nonzero syndrome names bit index plus one
  assign ecc_gen   = ecc_code(wdata);
  assign ecc_syn   = ecc_code(ecc_word_q[31:0]) ^ ecc_word_q[37:32];
  assign ecc_err   = (ecc_syn != 6'h0);
  always_comb begin
    ecc_fixed = ecc_word_q[31:0];
    for (int i = 0; i < 32; i++) begin
      if (ecc_syn == 6'(i + 1)) ecc_fixed[i] = ~ecc_word_q[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input voltage monitor
  logic [31:0] vin_scaled;
  logic        vin_ov, vin_uv, vin_off, vin_on_ok;

  assign vin_scaled = 32'(input_voltage_sense_pin) * vsc_q[19:0];
  assign vin_ov     = vin_scaled > vov_q;
  assign vin_uv     = vin_scaled < vuv_q;
  assign vin_off    = vin_scaled < voff_q;
  assign vin_on_ok  = vin_scaled > von_q;

  ////////////////////////////////////////////////////////////////////////
  // auxiliary averaging: 100us sample, 100ms interval
  logic [31:0]  smp_cnt_q;
  logic [15:0]  nsmp_q;
  logic [127:0] sum_q;
  logic [63:0]  avg_q;
  logic         smp_tick, int_end;

  assign smp_tick = (smp_cnt_q == SAMPLE_CYC - 1);
  assign int_end  = smp_tick && (nsmp_q == 16'(INTERVAL_SMP - 1));

  // running sum per channel, restarted each interval
  always_ff @(posedge clk) begin
    if (rst) begin
      smp_cnt_q <= 32'h0;
      nsmp_q    <= 16'h0;
      sum_q     <= 128'h0;
      avg_q     <= 64'h0;
    end else begin
      smp_cnt_q <= smp_tick ? 32'h0 : smp_cnt_q + 32'h1;
      if (smp_tick) begin
        nsmp_q <= int_end ? 16'h0 : nsmp_q + 16'h1;
        for (int c = 0; c < 4; c++) begin
          if (int_end) begin
            // 12-bit raw to 16-bit full scale, no trim applied
            avg_q[c*16 +: 16] <= 16'(((sum_q[c*32 +: 32]
              + 32'(aux_converter_in[c*12 +: 12])) * 32'd16)
              / INTERVAL_SMP);
            sum_q[c*32 +: 32] <= 32'h0;
          end else begin
            sum_q[c*32 +: 32] <= sum_q[c*32 +: 32]
              + 32'(aux_converter_in[c*12 +: 12]);
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // temperature smoothing of channel 0, one update per interval
  logic [31:0] tfilt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      tfilt_q          <= 32'h0;
      over_temp_sample <= 1'b0;
    end else begin
      over_temp_sample <= int_end;
      if (int_end) begin
        // first-order filter, tau near 1.55 s at 100 ms updates
        tfilt_q <= tfilt_q - (tfilt_q >> `TEMP_FILT_SHIFT)
                   + {16'h0, avg_q[15:0]};
      end
    end
  end
  assign temp_filtered = tfilt_q[`TEMP_FILT_SHIFT +: 16];

  ////////////////////////////////////////////////////////////////////////
  // ramp sequencer
  rail_supervision_pkg::rail_state_t st_q;
  logic [31:0] tick_cnt_q, dly_cnt_q;
  logic [15:0] vref_q;
  logic        pwm_q, fold_flt_q, ramp_tick, fold_act;
  logic [31:0] prebias_duty;
  logic        duty_ok, turn_on, stop_req;
  logic [15:0] fold_min16;

  assign ramp_tick    = (tick_cnt_q == RAMP_CYC - 1);
  // pre-bias duty as vref over vin in 16-bit fraction
  assign prebias_duty = (vin_scaled == 32'h0) ? 32'hffff :
         ({vref_q, 16'h0} / vin_scaled);
  assign duty_ok      = (prebias_duty > mind_q)
                        && (computed_duty > mind_q[15:0]);
  assign turn_on      = ctrl_q[`CTRL_ON_BIT] && vin_on_ok;
  assign stop_req     = !ctrl_q[`CTRL_ON_BIT] || vin_off || vin_uv;
  // foldback: output_current above limit, compared unfiltered
  assign fold_act     = (output_current > ocl_q[15:0]);

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_q <= 32'h0;
      dly_cnt_q  <= 32'h0;
      st_q       <= rail_supervision_pkg::RAIL_IDLE;
      vref_q     <= 16'h0;
      pwm_q      <= 1'b0;
      fold_flt_q <= 1'b0;
    end else begin
      tick_cnt_q <= ramp_tick ? 32'h0 : tick_cnt_q + 32'h1;
      if (vin_uv && ctrl_q[`CTRL_UVRESP_LSB +: 2]
          == rail_supervision_pkg::UV_SHUTDOWN) begin
        pwm_q <= 1'b0;
        st_q  <= rail_supervision_pkg::RAIL_IDLE;
      end else begin
        case (st_q)
          rail_supervision_pkg::RAIL_IDLE: begin
            pwm_q  <= 1'b0;
            vref_q <= differential_feedback_pins;
            if (turn_on && !fold_flt_q) begin
              st_q      <= rail_supervision_pkg::RAIL_DELAY;
              dly_cnt_q <= 32'h0;
            end
          end
          rail_supervision_pkg::RAIL_DELAY: begin
            if (!ctrl_q[`CTRL_ON_BIT])
              st_q <= rail_supervision_pkg::RAIL_IDLE;
            else if (ramp_tick) begin
              dly_cnt_q <= dly_cnt_q + 32'h1;
              if (dly_cnt_q + 32'h1 >= dly_q) begin
                st_q   <= rail_supervision_pkg::RAIL_RISE;
                // ramp from zero so pre-bias leaves the time unchanged
                vref_q <= 16'h0;
              end
            end
          end
          rail_supervision_pkg::RAIL_RISE: begin
            // enable once reference reaches output and duty is usable
            if (!pwm_q && vref_q >= differential_feedback_pins
                && duty_ok)
              pwm_q <= 1'b1;
            if (stop_req)
              st_q <= rail_supervision_pkg::RAIL_FALL;
            else if (ramp_tick) begin
              if (error_converter_sat_hi)
                vref_q <= vref_q + 16'h1;
              else if (error_converter_sat_lo)
                vref_q <= vref_q - 16'h1;
              else if (32'(vref_q) + rise_q >= vout_q) begin
                vref_q <= vout_q[15:0];
                st_q   <= rail_supervision_pkg::RAIL_REG;
              end else
                vref_q <= vref_q + rise_q[15:0];
            end
          end
          rail_supervision_pkg::RAIL_REG: begin
            pwm_q <= 1'b1;
            if (stop_req)
              st_q <= rail_supervision_pkg::RAIL_FALL;
            else if (fold_act && ramp_tick) begin
              if (differential_feedback_pins < fold_min16) begin
                fold_flt_q <= 1'b1;
                if (ctrl_q[`CTRL_FBRESP_BIT]) begin
                  pwm_q <= 1'b0;
                  st_q  <= rail_supervision_pkg::RAIL_IDLE;
                end
              end else if (vref_q != 16'h0)
                vref_q <= vref_q - 16'h1;
            end else if (!fold_act && ramp_tick
                         && vref_q < vout_q[15:0])
              vref_q <= vref_q + 16'h1;
          end
          rail_supervision_pkg::RAIL_FALL: begin
            if (ramp_tick) begin
              if (error_converter_sat_hi)
                vref_q <= vref_q + 16'h1;
              else if (error_converter_sat_lo)
                vref_q <= vref_q - 16'h1;
              else if (vref_q <= fall_q[15:0]) begin
                vref_q <= 16'h0;
                pwm_q  <= 1'b0;
                st_q   <= rail_supervision_pkg::RAIL_IDLE;
              end else
                vref_q <= vref_q - fall_q[15:0];
            end
          end
          default: st_q <= rail_supervision_pkg::RAIL_IDLE;
        endcase
      end
      if (wr && addr == `REG_STATUS && wdata[`ST_FOLDFLT_BIT]
          && !(st_q == rail_supervision_pkg::RAIL_REG && fold_act
               && differential_feedback_pins < fold_min16))
        fold_flt_q <= 1'b0;
    end
  end

  assign fold_min16 = fold_q[15:0];

  ////////////////////////////////////////////////////////////////////////
  // gain bank selection per mode
  logic [1:0] bank_d;
  assign bank_d = (st_q == rail_supervision_pkg::RAIL_REG)
    ? (ctrl_q[`CTRL_LIGHT_BIT] ? rail_supervision_pkg::BANK_LIGHT
                               : rail_supervision_pkg::BANK_NORM)
    : rail_supervision_pkg::BANK_RAMP;

  always_ff @(posedge clk) begin
    if (rst) begin
      gain_bank_sel <= 2'h0;
      gain_coeff    <= 32'h0;
    end else begin
      gain_bank_sel <= bank_d;
      gain_coeff    <= (bank_d == rail_supervision_pkg::BANK_NORM) ? gb1_q
                     : (bank_d == rail_supervision_pkg::BANK_LIGHT) ? gb2_q
                     : gb0_q;
    end
  end

  assign pulse_width_outputs_en = pwm_q;
  assign vref_dac               = vref_q;

  ////////////////////////////////////////////////////////////////////////
  // read mux, data one cycle after strobe
  logic [31:0] rd_mux, status_w;
  assign status_w = {21'h0, st_q, 3'h0, ecc_err, fold_flt_q,
                     fold_act, vin_uv, vin_ov};
  assign rd_mux =
      (addr == `REG_CTRL)        ? ctrl_q :
      (addr == `REG_VOUT_CMD)    ? vout_q :
      (addr == `REG_START_DELAY) ? dly_q  :
      (addr == `REG_RISE_STEP)   ? rise_q :
      (addr == `REG_FALL_STEP)   ? fall_q :
      (addr == `REG_MIN_DUTY)    ? mind_q :
      (addr == `REG_OC_LIMIT)    ? ocl_q  :
      (addr == `REG_FOLD_MIN)    ? fold_q :
      (addr == `REG_VIN_SCALE)   ? vsc_q  :
      (addr == `REG_VIN_OV)      ? vov_q  :
      (addr == `REG_VIN_UV)      ? vuv_q  :
      (addr == `REG_VIN_ON)      ? von_q  :
      (addr == `REG_VIN_OFF)     ? voff_q :
      (addr == `REG_STATUS)      ? status_w :
      (addr == `REG_VIN)         ? vin_scaled :
      (addr == `REG_AUX01)       ? avg_q[31:0] :
      (addr == `REG_AUX23)       ? avg_q[63:32] :
      (addr == `REG_TEMP_FILT)   ? {16'h0, temp_filtered} :
      (addr == `REG_GAIN_BANK0)  ? gb0_q :
      (addr == `REG_GAIN_BANK1)  ? gb1_q :
      (addr == `REG_GAIN_BANK2)  ? gb2_q :
      (addr == `REG_VREF)        ? {16'h0, vref_q} :
      (addr == `REG_ECC_WDATA)   ? eccw_q :
      (addr == `REG_ECC_CHECK)   ? {26'h0, ecc_word_q[37:32]} :
      (addr == `REG_ECC_RDATA)   ? ecc_fixed :
      32'h0;

  always_ff @(posedge clk) begin
    if (rst) rdata <= 32'h0;
    else if (rd) rdata <= rd_mux;
    else rdata <= 32'h0;
  end

endmodule : rail_supervision_and_soft_ramp

// ===== hw/rail_supervision_params.svh
`ifndef RAIL_SUPERVISION_PARAMS_SVH
`define RAIL_SUPERVISION_PARAMS_SVH

// clock and timing
`define CLK_MHZ            250
`define AUX_SAMPLE_US      100
`define AUX_SAMPLE_CYC     (`AUX_SAMPLE_US * `CLK_MHZ)
`define AUX_INTERVAL_MS    100
`define AUX_INTERVAL_SMP   ((`AUX_INTERVAL_MS * 1000) / `AUX_SAMPLE_US)
`define RAMP_RATE_KHZ      10
`define RAMP_TICK_CYC      ((`CLK_MHZ * 1000) / `RAMP_RATE_KHZ)
`define TEMP_TAU_MS        1550
`define TEMP_FILT_SHIFT    4

// register offsets
`define REG_CTRL           8'h00
`define REG_VOUT_CMD       8'h04
`define REG_START_DELAY    8'h08
`define REG_RISE_STEP      8'h0c
`define REG_FALL_STEP      8'h10
`define REG_MIN_DUTY       8'h14
`define REG_OC_LIMIT       8'h18
`define REG_FOLD_MIN       8'h1c
`define REG_VIN_SCALE      8'h20
`define REG_VIN_OV         8'h24
`define REG_VIN_UV         8'h28
`define REG_VIN_ON         8'h2c
`define REG_VIN_OFF        8'h30
`define REG_STATUS         8'h34
`define REG_VIN            8'h38
`define REG_AUX01          8'h3c
`define REG_AUX23          8'h40
`define REG_TEMP_FILT      8'h44
`define REG_GAIN_BANK0     8'h48
`define REG_GAIN_BANK1     8'h4c
`define REG_GAIN_BANK2     8'h50
`define REG_VREF           8'h54
`define REG_ECC_WDATA      8'h58
`define REG_ECC_CHECK      8'h5c
`define REG_ECC_RDATA      8'h60

// ctrl fields
`define CTRL_ON_BIT        0
`define CTRL_LIGHT_BIT     1
`define CTRL_UVRESP_LSB    2
`define CTRL_FBRESP_BIT    4

// status fields
`define ST_OV_BIT          0
`define ST_UV_BIT          1
`define ST_FOLD_BIT        2
`define ST_FOLDFLT_BIT     3
`define ST_ECCERR_BIT      4
`define ST_STATE_LSB       8

`endif

// ===== hw/rail_supervision_pkg.sv
package rail_supervision_pkg;
  typedef enum logic [2:0] {
    RAIL_IDLE  = 3'b000,
    RAIL_DELAY = 3'b001,
    RAIL_RISE  = 3'b010,
    RAIL_REG   = 3'b011,
    RAIL_FALL  = 3'b100
  } rail_state_t;
  typedef enum logic [1:0] {
    UV_CONTINUE    = 2'b00,
    UV_CONT_DELAY  = 2'b01,
    UV_SHUTDOWN    = 2'b10
  } uv_resp_t;
  typedef enum logic [1:0] {
    BANK_RAMP  = 2'b00,
    BANK_NORM  = 2'b01,
    BANK_LIGHT = 2'b10
  } gain_bank_t;
endpackage : rail_supervision_pkg

// ===== verification/rail_supervision_properties.sv
`timescale 1ns/1ps
`include "rail_supervision_params.svh"
module rail_supervision_checker #(
  parameter int unsigned SAMPLE_CYC   = 4,
  parameter int unsigned INTERVAL_SMP = 4
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // sense and control
  input wire logic [11:0] input_voltage_sense_pin,
  input wire logic [15:0] differential_feedback_pins,
  input wire logic [15:0] output_current,
  input wire logic [15:0] computed_duty,
  input wire logic        pulse_width_outputs_en,
  input wire logic [15:0] vref_dac,
  input wire logic [1:0]  gain_bank_sel,
  input wire logic        over_temp_sample
);
  localparam int PERIOD = int'(SAMPLE_CYC * INTERVAL_SMP);
  logic [31:0] ctrl_q, oc_q, min_q, on_q, uv_q, scale_q, vin_s, fold_q;
  logic        en;
  assign en = pulse_width_outputs_en;
  assign vin_s = 32'(input_voltage_sense_pin) * scale_q;
  // shadow copies of the settings the rules depend on
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= 32'h0;
      oc_q <= 32'h0000ffff;
      min_q <= 32'h0;
      on_q <= 32'h0;
      uv_q <= 32'h0;
      scale_q <= 32'h1;
      fold_q <= 32'h0;
    end else if (wr) begin
      case (addr)
        `REG_CTRL: ctrl_q <= wdata;
        `REG_OC_LIMIT: oc_q <= wdata;
        `REG_MIN_DUTY: min_q <= wdata;
        `REG_VIN_ON: on_q <= wdata;
        `REG_VIN_UV: uv_q <= wdata;
        `REG_VIN_SCALE: scale_q <= wdata;
        `REG_FOLD_MIN: fold_q <= wdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  property p_rdata_idle; !$past(rd) |-> rdata == 32'h0; endproperty
  property p_unmapped;
    $past(rd) && $past(addr) > `REG_ECC_RDATA |-> rdata == 32'h0;
  endproperty
  property p_uv_shut;
    ctrl_q[3:2] == 2'b10 && vin_s < uv_q |-> ##[1:3] !en;
  endproperty
  property p_idle_track;
    (!ctrl_q[0] && !en && $stable(differential_feedback_pins))[*6]
      |-> vref_dac == differential_feedback_pins;
  endproperty
  property p_start_gate; $rose(en) |-> ctrl_q[0] && vin_s > on_q; endproperty
  property p_min_pulse;
    $rose(en) |-> $past(computed_duty) > min_q[15:0];
  endproperty
  property p_bank_ramp;
    $rose(en) |-> gain_bank_sel == rail_supervision_pkg::BANK_RAMP;
  endproperty
  property p_temp_pulse; over_temp_sample |=> !over_temp_sample; endproperty
  property p_temp_period;
    over_temp_sample |-> ##PERIOD over_temp_sample;
  endproperty
  property p_fold;
    (output_current > oc_q[15:0] && en
      && differential_feedback_pins >= fold_q[15:0])[*8]
      |-> vref_dac < $past(vref_dac, 8);
  endproperty
  property p_tick;
    en && $changed(vref_dac) |=> $stable(vref_dac)[*3];
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_uv_shut: assert property (p_uv_shut) else $error("no uv shutdown");
  a_idle_track: assert property (p_idle_track) else $error("idle ref");
  a_start_gate: assert property (p_start_gate) else $error("early on");
  a_min_pulse: assert property (p_min_pulse) else $error("min pulse");
  a_bank_ramp: assert property (p_bank_ramp) else $error("bank");
  a_temp_pulse: assert property (p_temp_pulse) else $error("pulse");
  a_temp_period: assert property (p_temp_period) else $error("period");
  a_fold: assert property (p_fold) else $error("no foldback");
  a_tick: assert property (p_tick) else $error("ramp rate");
  c_start: cover property ($rose(en));
  c_fold: cover property (output_current > oc_q[15:0] && en);
  c_uv: cover property (ctrl_q[3:2] == 2'b10 && vin_s < uv_q && en);
endmodule : rail_supervision_checker
bind rail_supervision_and_soft_ramp rail_supervision_checker #(
  .SAMPLE_CYC(SAMPLE_CYC), .INTERVAL_SMP(INTERVAL_SMP)
) i_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .input_voltage_sense_pin(input_voltage_sense_pin),
  .differential_feedback_pins(differential_feedback_pins),
  .output_current(output_current), .computed_duty(computed_duty),
  .pulse_width_outputs_en(pulse_width_outputs_en), .vref_dac(vref_dac),
  .gain_bank_sel(gain_bank_sel), .over_temp_sample(over_temp_sample)
);

// ===== verification/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model (
  // bench settings
  input  wire logic [15:0] prebias,
  input  wire logic [15:0] load,
  // controller side
  input  wire logic        pwm_en,
  input  wire logic [15:0] vref,
  output logic      [15:0] fb,
  output logic      [15:0] cur,
  output logic      [15:0] duty,
  output logic             sat_hi,
  output logic             sat_lo
);
  // output follows the reference while switching, else keeps pre-bias
  assign fb = (pwm_en === 1'b1) ? vref : prebias;
  assign cur = (pwm_en === 1'b1) ? load : 16'h0;
  // duty not below the pre-bias level while off, equal to vref while switching; no saturation modelled
  assign duty = (pwm_en === 1'b1 || vref > prebias) ? vref : prebias;
  assign sat_hi = 1'b0;
  assign sat_lo = 1'b0;
endmodule : power_stage_model

// ===== verification/rail_supervision_and_soft_ramp_tb.sv
`timescale 1ns/1ps
`include "rail_supervision_params.svh"
module rail_supervision_and_soft_ramp_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [11:0] vin = 12'h800;
  logic [15:0] prebias = 16'h0040;
  logic [15:0] load = 16'h0;
  logic [47:0] aux = {12'h004, 12'h003, 12'h002, 12'h001};
  logic [31:0] rdata, v, coeff;
  logic [15:0] fb, cur, duty, vref;
  logic        en, sat_hi, sat_lo;
  logic [1:0]  bank;
  int          n_errors = 0;
  int          compares = 0;
  int          n;
  always #2 clk = ~clk;
  rail_supervision_and_soft_ramp #(
    .SAMPLE_CYC(4), .INTERVAL_SMP(4), .RAMP_CYC(4)
  ) i_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .input_voltage_sense_pin(vin),
    .differential_feedback_pins(fb), .output_current(cur),
    .error_converter_sat_hi(sat_hi), .error_converter_sat_lo(sat_lo),
    .computed_duty(duty), .aux_converter_in(aux),
    .pulse_width_outputs_en(en), .vref_dac(vref), .gain_bank_sel(bank),
    .gain_coeff(coeff), .over_temp_sample(), .temp_filtered()
  );
  power_stage_model i_stage (
    .prebias(prebias), .load(load), .pwm_en(en), .vref(vref), .fb(fb),
    .cur(cur), .duty(duty), .sat_hi(sat_hi), .sat_lo(sat_lo)
  );
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test();
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle register strobes
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  // poll the state field, bounded
  task automatic wait_state(input logic [2:0] s, input int max);
    n = 0;
    v = 32'h0;
    while (v[10:8] !== s && n < max) begin
      rd_reg(`REG_STATUS);
      n++;
    end
    if (v[10:8] !== s) begin
      chk(32'(v[10:8]), 32'(s));
      stop_test();
    end
  endtask : wait_state
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`REG_STATUS);
    chk(v, 32'h0);
    rd_reg(`REG_OC_LIMIT);
    chk(v, 32'h0000ffff);
    wr_reg(8'h70, 32'h1234);
    rd_reg(8'h70);
    chk(v, 32'h0);
    chk(32'(vref), 32'h40);
    repeat (40) @(posedge clk);
    rd_reg(`REG_AUX01);
    chk(v, 32'h00200010);
    rd_reg(`REG_AUX23);
    chk(v, 32'h00400030);
    // single-bit upsets under stored check bits
    for (int b = 0; b < 32; b += 9) begin
      wr_reg(`REG_ECC_WDATA, 32'h5a3c96e1);
      rd_reg(`REG_ECC_CHECK);
      chk(v & 32'hffffffc0, 32'h0);
      wr_reg(`REG_ECC_WDATA, 32'h5a3c96e1 ^ (32'h1 << b));
      wr_reg(`REG_ECC_CHECK, v);
      rd_reg(`REG_ECC_RDATA);
      chk(v, 32'h5a3c96e1);
    end
    wr_reg(`REG_GAIN_BANK1, 32'h1111);
    wr_reg(`REG_VOUT_CMD, 32'h100);
    wr_reg(`REG_START_DELAY, 32'h2);
    wr_reg(`REG_RISE_STEP, 32'h10);
    wr_reg(`REG_FALL_STEP, 32'h20);
    wr_reg(`REG_MIN_DUTY, 32'h10);
    wr_reg(`REG_VIN_OFF, 32'h400);
    wr_reg(`REG_VIN_UV, 32'h200);
    wr_reg(`REG_VIN_ON, 32'h900);
    wr_reg(`REG_CTRL, 32'h1);
    repeat (100) @(posedge clk);
    chk(32'(en), 32'h0);
    // 2 delay ticks plus 16 rise ticks of 4 cycles, 2 cycles a poll
    wr_reg(`REG_VIN_ON, 32'h700);
    wait_state(rail_supervision_pkg::RAIL_REG, 60);
    chk(32'(n >= 32 && n <= 42), 32'h1);
    chk(32'(vref), 32'h100);
    chk(32'(en), 32'h1);
    chk(32'(bank), 32'(rail_supervision_pkg::BANK_NORM));
    chk(coeff, 32'h1111);
    wr_reg(`REG_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    chk(32'(bank), 32'(rail_supervision_pkg::BANK_LIGHT));
    wr_reg(`REG_CTRL, 32'h1);
    // overload, then pull the output under the foldback floor
    wr_reg(`REG_FOLD_MIN, 32'hf0);
    wr_reg(`REG_OC_LIMIT, 32'h80);
    load <= 16'h100;
    repeat (30) @(posedge clk);
    rd_reg(`REG_STATUS);
    chk(32'(v[2]), 32'h1);
    chk(32'(vref < 16'h100), 32'h1);
    repeat (80) @(posedge clk);
    rd_reg(`REG_STATUS);
    chk(32'(v[3]), 32'h1);
    load <= 16'h0;
    wr_reg(`REG_OC_LIMIT, 32'hffff);
    wr_reg(`REG_STATUS, 32'h8);
    rd_reg(`REG_STATUS);
    chk(32'(v[3]), 32'h0);
    // input under turn-off: soft stop, not an abrupt cut
    vin <= 12'h300;
    repeat (6) @(posedge clk);
    rd_reg(`REG_STATUS);
    chk(32'(v[10:8]), 32'(rail_supervision_pkg::RAIL_FALL));
    n = 0;
    while (en !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(32'(en), 32'h0);
    if (n == 200) stop_test();
    // restart with immediate shutdown on undervoltage
    wr_reg(`REG_CTRL, 32'h9);
    vin <= 12'h800;
    wait_state(rail_supervision_pkg::RAIL_REG, 80);
    vin <= 12'h100;
    repeat (3) @(posedge clk);
    chk(32'(en), 32'h0);
    rd_reg(`REG_STATUS);
    chk(32'(v[1:0]), 32'h2);
    wr_reg(`REG_VIN_OV, 32'hff);
    rd_reg(`REG_STATUS);
    chk(32'(v[1:0]), 32'h3);
    stop_test();
  end
endmodule : rail_supervision_and_soft_ramp_tb
